// ---- core/rsar_regs.sv ----
// module: range select and alarm status register bank with apb slave
`timescale 1ns/1ns
// Notes on behaviour
// - reserved bits, including upper sixteen, always read zero.
// - bit 6 of range register disables the internal reference when one.
// - codes 0 to 4 pick bipolar ranges 3, 2.5, 1.5, 1.25, 0.625 x ref.
// - codes 8 to b pick unipolar ranges 3, 2.5, 1.5, 1.25 x ref.
// - reset gives range code zero and reference enabled.
// - bits 15 and 14 show live supply low and high alarms.
// - bits 11 and 10 show live input low and high alarms.
// - bits 7 and 6 latch supply low and high alarms.
// - bits 5 and 4 latch input low and high alarms.
// - bit 0 is the OR of the four latched flags.
// - flags are one when the alarm exists, read-only, reset zero.
// - alarm status is read-only at byte offset 20h; writes ignored.
// - high input compare uses upper limit with two zero bits appended.
// - low input compare uses lower limit with two zero bits appended.
module rsar_regs #(
    parameter int RES_W = 18
) (
    // clock and reset
    input  wire logic             clk_in,
    input  wire logic             nrst_in,
    // apb slave
    input  wire logic             psel_in,
    input  wire logic             penable_in,
    input  wire logic             pwrite_in,
    input  wire logic [7:0]       paddr_in,
    input  wire logic [31:0]      pwdata_in,
    input  wire logic [3:0]       pstrb_in,
    output logic [31:0]           prdata_out,
    output logic                  pready_out,
    output logic                  pslverr_out,
    // alarm sources
    input  wire logic             sample_valid_in,
    input  wire logic [RES_W-1:0] sample_in,
    input  wire logic             supply_low_in,
    input  wire logic             supply_high_in,
    // configuration and interrupt outputs
    output logic [3:0]            range_code_out,
    output logic                  internal_ref_off_out,
    output logic                  irq_out
);
    ////////////////////////////////////////////////////////////////////////
    logic [3:0]          range_code;
    logic                internal_ref_off;
    logic [15:0]         input_upper_limit;
    logic [15:0]         input_lower_limit;
    rsar_pkg::rsar_flags_t latched;
    rsar_pkg::rsar_flags_t live;
    rsar_pkg::rsar_flags_t irq_stat;
    rsar_pkg::rsar_flags_t irq_mask;
    logic                in_above;
    logic                in_below;
    logic                access;
    logic                wr_en;
    logic                rd_alarm;
    logic [31:0]         next_rdata;
    logic                mapped;

    // is the code one of the nine documented ranges
    function automatic logic range_legal(input logic [3:0] code);
        unique case (code)
            rsar_pkg::RSAR_BI_3_0, rsar_pkg::RSAR_BI_2_5, rsar_pkg::RSAR_BI_1_5,
            rsar_pkg::RSAR_BI_1_25, rsar_pkg::RSAR_BI_0_625,
            rsar_pkg::RSAR_UNI_3_0, rsar_pkg::RSAR_UNI_2_5,
            rsar_pkg::RSAR_UNI_1_5, rsar_pkg::RSAR_UNI_1_25: range_legal = 1'b1;
            default: range_legal = 1'b0;
        endcase
    endfunction

    // pack the four flags into the fixed latched-flag bit positions 7 to 4
    function automatic logic [31:0] place_flags(input rsar_pkg::rsar_flags_t f);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[rsar_pkg::IN_HIGH_LAT_BIT]  = f.in_high;
        w[rsar_pkg::IN_LOW_LAT_BIT]   = f.in_low;
        w[rsar_pkg::SUP_HIGH_LAT_BIT] = f.sup_high;
        w[rsar_pkg::SUP_LOW_LAT_BIT]  = f.sup_low;
        place_flags = w;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // input window comparator
    rsar_cmp #(
        .RES_W(RES_W)
    ) u_cmp (
        .clk_in              (clk_in),
        .nrst_in             (nrst_in),
        .sample_valid_in     (sample_valid_in),
        .sample_in           (sample_in),
        .input_upper_limit_in(input_upper_limit),
        .input_lower_limit_in(input_lower_limit),
        .above_out           (in_above),
        .below_out           (in_below)
    );

    // live flags are high while alarm exists
    assign live = '{sup_low: supply_low_in, sup_high: supply_high_in,
                    in_low: in_below, in_high: in_above};

    ////////////////////////////////////////////////////////////////////////
    // zero wait state slave: every access completes in its first access cycle
    assign access      = psel_in && penable_in;
    assign wr_en       = access && pwrite_in;
    assign rd_alarm    = access && !pwrite_in && paddr_in == rsar_pkg::ALARM_OFFSET;
    assign pready_out  = 1'b1;
    assign mapped      = paddr_in inside {rsar_pkg::RANGE_OFFSET, rsar_pkg::ALARM_OFFSET,
                                          rsar_pkg::THRESH_HI_OFFSET,
                                          rsar_pkg::THRESH_LO_OFFSET,
                                          rsar_pkg::IRQ_STAT_OFFSET,
                                          rsar_pkg::IRQ_MASK_OFFSET};
    // unmapped address answers with an error, no side effect
    assign pslverr_out = access && !mapped;

    // range configuration register; low byte lane only holds fields
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            // reset to widest bipolar range, reference on
            range_code       <= rsar_pkg::RANGE_RESET;
            internal_ref_off <= rsar_pkg::REF_OFF_RESET;
        end else if (wr_en && paddr_in == rsar_pkg::RANGE_OFFSET && pstrb_in[0]) begin
            internal_ref_off <= pwdata_in[rsar_pkg::REF_OFF_BIT];
            // undefined codes are dropped, range kept
            if (range_legal(pwdata_in[rsar_pkg::RANGE_CODE_LSB +: 4])) begin
                range_code <= pwdata_in[rsar_pkg::RANGE_CODE_LSB +: 4];
            end
        end
    end

    // range code drives the front end directly
    // unipolar codes pass through the same path
    assign range_code_out       = range_code;
    assign internal_ref_off_out = internal_ref_off;

    // threshold registers, byte-lane writes
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            input_upper_limit <= rsar_pkg::UPPER_LIMIT_RESET;
            input_lower_limit <= rsar_pkg::LOWER_LIMIT_RESET;
        end else if (wr_en) begin
            for (int b = 0; b < 2; b++) begin
                if (pstrb_in[b] && paddr_in == rsar_pkg::THRESH_HI_OFFSET) begin
                    input_upper_limit[b*8 +: 8] <= pwdata_in[b*8 +: 8];
                end
                if (pstrb_in[b] && paddr_in == rsar_pkg::THRESH_LO_OFFSET) begin
                    input_lower_limit[b*8 +: 8] <= pwdata_in[b*8 +: 8];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // latched alarm flags; a live alarm in the read cycle wins over the clear
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            latched <= '0;
        end else begin
            latched <= live | (rd_alarm ? rsar_pkg::rsar_flags_t'(4'h0) : latched);
        end
    end

    // interrupt status: set on new latch, write-one-to-clear, set wins
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            irq_stat <= '0;
            irq_mask <= '0;
        end else begin
            if (wr_en && paddr_in == rsar_pkg::IRQ_MASK_OFFSET && pstrb_in[0]) begin
                irq_mask <= rsar_pkg::rsar_flags_t'(pwdata_in[rsar_pkg::IN_HIGH_LAT_BIT +: 4]);
            end
            if (wr_en && paddr_in == rsar_pkg::IRQ_STAT_OFFSET && pstrb_in[0]) begin
                irq_stat <= (irq_stat & ~rsar_pkg::rsar_flags_t'(
                             pwdata_in[rsar_pkg::IN_HIGH_LAT_BIT +: 4])) | (live & ~latched);
            end else begin
                irq_stat <= irq_stat | (live & ~latched);
            end
        end
    end

    // level interrupt while any unmasked status bit is set
    assign irq_out = |(irq_stat & irq_mask);

    ////////////////////////////////////////////////////////////////////////
    // read mux; alarm register has no write path at all
    always_comb begin
        next_rdata = 32'h0000_0000;
        unique case (paddr_in)
            rsar_pkg::RANGE_OFFSET: begin
                next_rdata[rsar_pkg::RANGE_CODE_LSB +: 4] = range_code;
                next_rdata[rsar_pkg::REF_OFF_BIT]         = internal_ref_off;
            end
            rsar_pkg::ALARM_OFFSET: begin
                next_rdata[rsar_pkg::SUP_LOW_ACT_BIT]  = live.sup_low;
                next_rdata[rsar_pkg::SUP_HIGH_ACT_BIT] = live.sup_high;
                next_rdata[rsar_pkg::IN_LOW_ACT_BIT]   = live.in_low;
                next_rdata[rsar_pkg::IN_HIGH_ACT_BIT]  = live.in_high;
                next_rdata = next_rdata | place_flags(latched);
                next_rdata[rsar_pkg::SUMMARY_BIT] = |latched;
            end
            rsar_pkg::THRESH_HI_OFFSET: next_rdata[15:0] = input_upper_limit;
            rsar_pkg::THRESH_LO_OFFSET: next_rdata[15:0] = input_lower_limit;
            rsar_pkg::IRQ_STAT_OFFSET:  next_rdata = place_flags(irq_stat);
            rsar_pkg::IRQ_MASK_OFFSET:  next_rdata = place_flags(irq_mask);
            default:                    next_rdata = 32'h0000_0000;
        endcase
    end

    // reserved bits left at zero by the mux
    assign prdata_out = (access && !pwrite_in) ? next_rdata : 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////
    // checks
    a_reserved_zero: assert property (@(posedge clk_in) disable iff (!nrst_in)
        access && !pwrite_in |-> prdata_out[31:16] == 16'h0000)
        else $error("reserved upper bits read nonzero");
    a_ref_off_write: assert property (@(posedge clk_in) disable iff (!nrst_in)
        wr_en && paddr_in == rsar_pkg::RANGE_OFFSET && pstrb_in[0]
        |=> internal_ref_off_out == $past(pwdata_in[6]))
        else $error("reference disable bit not taken");
    a_range_legal: assert property (@(posedge clk_in) disable iff (!nrst_in)
        range_legal(range_code_out))
        else $error("range code outside defined set");
    a_range_bad_kept: assert property (@(posedge clk_in) disable iff (!nrst_in)
        wr_en && paddr_in == rsar_pkg::RANGE_OFFSET && !range_legal(pwdata_in[3:0])
        |=> $stable(range_code_out))
        else $error("undefined range code accepted");
    a_live_supply: assert property (@(posedge clk_in) disable iff (!nrst_in)
        rd_alarm |-> prdata_out[15] == supply_low_in && prdata_out[14] == supply_high_in)
        else $error("live supply flags wrong");
    a_latch_holds: assert property (@(posedge clk_in) disable iff (!nrst_in)
        supply_low_in ##1 !rd_alarm |-> latched.sup_low)
        else $error("latched flag lost before read");
    a_read_clears: assert property (@(posedge clk_in) disable iff (!nrst_in)
        rd_alarm && !supply_high_in |=> !latched.sup_high)
        else $error("latched flag not cleared by read");
    a_summary_or: assert property (@(posedge clk_in) disable iff (!nrst_in)
        rd_alarm |-> prdata_out[0] == |{prdata_out[7:4]})
        else $error("summary bit differs from flag OR");
    a_alarm_ro: assert property (@(posedge clk_in) disable iff (!nrst_in)
        wr_en && paddr_in == rsar_pkg::ALARM_OFFSET && !(|live) |=> latched == $past(latched))
        else $error("alarm register changed by write");
endmodule

// ---- core/rsar_pkg.sv ----
// package: register map, field positions, reset values and range codes
package rsar_pkg;
    // register byte offsets
    localparam logic [7:0] RANGE_OFFSET     = 8'h14;
    localparam logic [7:0] ALARM_OFFSET     = 8'h20;
    localparam logic [7:0] THRESH_HI_OFFSET = 8'h24;
    localparam logic [7:0] THRESH_LO_OFFSET = 8'h28;
    localparam logic [7:0] IRQ_STAT_OFFSET  = 8'h30;
    localparam logic [7:0] IRQ_MASK_OFFSET  = 8'h34;
    // range configuration fields
    localparam int RANGE_CODE_LSB = 0;
    localparam int REF_OFF_BIT    = 6;
    localparam logic [3:0] RANGE_RESET   = 4'h0;
    localparam logic       REF_OFF_RESET = 1'h0;
    // alarm status bit positions
    localparam int SUP_LOW_ACT_BIT  = 15;
    localparam int SUP_HIGH_ACT_BIT = 14;
    localparam int IN_LOW_ACT_BIT   = 11;
    localparam int IN_HIGH_ACT_BIT  = 10;
    localparam int SUP_LOW_LAT_BIT  = 7;
    localparam int SUP_HIGH_LAT_BIT = 6;
    localparam int IN_LOW_LAT_BIT   = 5;
    localparam int IN_HIGH_LAT_BIT  = 4;
    localparam int SUMMARY_BIT      = 0;
    // threshold reset values
    localparam logic [15:0] UPPER_LIMIT_RESET = 16'hffff;
    localparam logic [15:0] LOWER_LIMIT_RESET = 16'h0000;
    // range codes
    typedef enum logic [3:0] {
        RSAR_BI_3_0   = 4'h0,
        RSAR_BI_2_5   = 4'h1,
        RSAR_BI_1_5   = 4'h2,
        RSAR_BI_1_25  = 4'h3,
        RSAR_BI_0_625 = 4'h4,
        RSAR_UNI_3_0  = 4'h8,
        RSAR_UNI_2_5  = 4'h9,
        RSAR_UNI_1_5  = 4'ha,
        RSAR_UNI_1_25 = 4'hb
    } rsar_range_t;
    // four latched flags: supply low, supply high, input low, input high
    typedef struct packed {
        logic sup_low;
        logic sup_high;
        logic in_low;
        logic in_high;
    } rsar_flags_t;
endpackage

// ---- core/rsar_cmp.sv ----
// module: input-voltage window comparator against 18-bit sample
`timescale 1ns/1ns
module rsar_cmp #(
    parameter int RES_W = 18
) (
    // clock and reset
    input  wire logic             clk_in,
    input  wire logic             nrst_in,
    // sample and limits
    input  wire logic             sample_valid_in,
    input  wire logic [RES_W-1:0] sample_in,
    input  wire logic [15:0]      input_upper_limit_in,
    input  wire logic [15:0]      input_lower_limit_in,
    // registered alarm levels
    output logic                  above_out,
    output logic                  below_out
);
    logic [RES_W-1:0] upper_ext;
    logic [RES_W-1:0] lower_ext;

    assign upper_ext = {input_upper_limit_in, 2'b00};
    assign lower_ext = {input_lower_limit_in, 2'b00};

    // levels update only on a fresh sample so they follow conversions
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            above_out <= 1'b0;
            below_out <= 1'b0;
        end else if (sample_valid_in) begin
            above_out <= sample_in > upper_ext;
            below_out <= sample_in < lower_ext;
        end
    end
endmodule

// ---- testbench/rsar_regs_tb.sv ----
// testbench: apb-driven checks of range select and alarm status registers
`timescale 1ns/1ns
module rsar_regs_tb;
    logic        clk_in          = 1'b0;
    logic        nrst_in         = 1'b0;
    logic        psel            = 1'b0;
    logic        penable         = 1'b0;
    logic        pwrite          = 1'b0;
    logic [7:0]  paddr           = 8'h00;
    logic [31:0] pwdata          = 32'h0;
    logic [3:0]  pstrb           = 4'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        sample_valid    = 1'b0;
    logic [17:0] sample          = 18'h0;
    logic        supply_low      = 1'b0;
    logic        supply_high     = 1'b0;
    logic [3:0]  range_code;
    logic        ref_off;
    logic        irq;
    int          miscompares     = 0;
    int          check_count     = 0;
    logic [3:0]  codes [9]       = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'h9, 4'ha, 4'hb};
    logic [31:0] rd_word;
    logic        rd_err;
    logic        ref_bit;
    logic [3:0]  wr_strb         = 4'hf;

    ////////////////////////////////////////////////////////////////////////////////
    // clock at 125 MHz and device under test
    always #4 clk_in = ~clk_in;

    rsar_regs dut_u (
        .clk_in               (clk_in),
        .nrst_in              (nrst_in),
        .psel_in              (psel),
        .penable_in           (penable),
        .pwrite_in            (pwrite),
        .paddr_in             (paddr),
        .pwdata_in            (pwdata),
        .pstrb_in             (pstrb),
        .prdata_out           (prdata),
        .pready_out           (pready),
        .pslverr_out          (pslverr),
        .sample_valid_in      (sample_valid),
        .sample_in            (sample),
        .supply_low_in        (supply_low),
        .supply_high_in       (supply_high),
        .range_code_out       (range_code),
        .internal_ref_off_out (ref_off),
        .irq_out              (irq)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // shared tasks: compare, apb transfer, stimulus
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // the request is held until pready is seen high at a rising edge
    // no local limit: only the watchdog ends a wait that never sees pready
    task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
                        output logic [31:0] rd, output logic err);
        @(posedge clk_in);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= wd;
        pstrb   <= wr ? wr_strb : 4'h0;   // reads carry no strobes
        @(posedge clk_in);
        penable <= 1'b1;
        @(posedge clk_in);
        while (pready !== 1'b1) begin
            @(posedge clk_in);
        end
        rd  = prdata;
        err = pslverr;
        check({31'h0, pready}, 32'h1, "pready at transfer end");
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] addr, input logic [31:0] data);
        logic [31:0] rd;
        logic        err;
        xfer(1'b1, addr, data, rd, err);
    endtask

    task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp);
        logic [31:0] rd;
        logic        err;
        xfer(1'b0, addr, 32'h0, rd, err);
        check(rd, exp, "read data");
        check({31'h0, err}, 32'h0, "slave error");
    endtask

    // a single-cycle sample pulse, then time for compare and latch to settle
    task automatic pulse_sample(input logic [17:0] val);
        @(posedge clk_in);
        sample_valid <= 1'b1;
        sample       <= val;
        @(posedge clk_in);
        sample_valid <= 1'b0;
        repeat (3) @(posedge clk_in);
    endtask

    task automatic final_report;
        if (miscompares == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // watchdog: the whole sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk_in);
        miscompares++;
        final_report();
    end

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (4) @(posedge clk_in);
        nrst_in <= 1'b1;
        rd_chk(8'h14, 32'h0);
        rd_chk(8'h20, 32'h0);
        rd_chk(8'h24, 32'h0000ffff);
        rd_chk(8'h28, 32'h0);
        check({27'h0, ref_off, range_code}, 32'h0, "reset outputs");
        // every range code, reserved bits written as ones
        for (int i = 0; i < 9; i++) begin
            ref_bit = i[0];
            wr(8'h14, 32'hffffffb0 | {25'h0, ref_bit, 6'h0} | {28'h0, codes[i]});
            rd_chk(8'h14, {25'h0, ref_bit, 2'b00, codes[i]});
            check({27'h0, ref_off, range_code}, {27'h0, ref_bit, codes[i]}, "range");
        end
        // undefined code keeps range b, reference bit still taken
        wr(8'h14, 32'h00000045);
        rd_chk(8'h14, 32'h0000004b);
        // unmapped address answers with error and zero data
        xfer(1'b0, 8'h40, 32'h0, rd_word, rd_err);
        check(rd_word, 32'h0, "unmapped read");
        check({31'h0, rd_err}, 32'h1, "unmapped error");
        // supply low with its interrupt masked
        wr(8'h34, 32'h0);
        @(posedge clk_in);
        supply_low <= 1'b1;
        repeat (3) @(posedge clk_in);
        check({31'h0, irq}, 32'h0, "masked irq");
        rd_chk(8'h20, 32'h00008081);
        @(posedge clk_in);
        supply_low <= 1'b0;
        repeat (3) @(posedge clk_in);
        wr(8'h20, 32'h0);
        rd_chk(8'h20, 32'h00000081);
        rd_chk(8'h20, 32'h0);
        rd_chk(8'h30, 32'h00000080);
        wr(8'h30, 32'h00000080);
        rd_chk(8'h30, 32'h0);
        // supply high with interrupts unmasked
        wr(8'h34, 32'h000000f0);
        @(posedge clk_in);
        supply_high <= 1'b1;
        repeat (3) @(posedge clk_in);
        check({31'h0, irq}, 32'h1, "irq raised");
        rd_chk(8'h20, 32'h00004041);
        wr(8'h30, 32'h00000040);
        // let the clearing edge settle before looking at the level
        @(posedge clk_in);
        check({31'h0, irq}, 32'h0, "irq cleared");
        @(posedge clk_in);
        supply_high <= 1'b0;
        repeat (3) @(posedge clk_in);
        rd_chk(8'h20, 32'h00000041);
        rd_chk(8'h20, 32'h0);
        // input high: limit 1000h compares against 4000h, strictly above
        wr(8'h24, 32'h00001000);
        rd_chk(8'h24, 32'h00001000);
        pulse_sample(18'h04001);
        rd_chk(8'h20, 32'h00000411);
        pulse_sample(18'h04000);
        rd_chk(8'h20, 32'h00000011);
        rd_chk(8'h20, 32'h0);
        // input low: limit 0100h compares against 0400h, strictly below
        wr(8'h28, 32'h00000100);
        pulse_sample(18'h003ff);
        rd_chk(8'h20, 32'h00000821);
        pulse_sample(18'h00400);
        rd_chk(8'h20, 32'h00000021);
        rd_chk(8'h20, 32'h0);
        wr(8'h30, 32'h000000f0);
        // byte strobes: lane 0 alone on the upper limit, no lane 0 on the range
        wr_strb = 4'h1;
        wr(8'h24, 32'h000077ee);
        wr_strb = 4'he;
        wr(8'h14, 32'h00000041);
        wr_strb = 4'hf;
        rd_chk(8'h24, 32'h000010ee);
        rd_chk(8'h14, 32'h0000004b);
        // one-cycle supply low pulse latches and raises the unmasked irq
        @(posedge clk_in);
        supply_low <= 1'b1;
        @(posedge clk_in);
        supply_low <= 1'b0;
        repeat (2) @(posedge clk_in);
        check({31'h0, irq}, 32'h1, "irq before reset");
        // a second reset in mid-run restores defaults and drops latches
        @(posedge clk_in);
        nrst_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        nrst_in <= 1'b1;
        rd_chk(8'h14, 32'h0);
        check({27'h0, ref_off, range_code}, 32'h0, "second reset");
        rd_chk(8'h20, 32'h0);
        check({31'h0, irq}, 32'h0, "irq after reset");
        final_report();
    end
endmodule
